// >>> core/hbap_pkg.sv
// Shared constants and types for the host bus arbitration pin block
package hbap_pkg;
  localparam int MP_LINES      = 6;    // Multiprocessor bus request lines
  localparam int ID_W          = 3;    // Width of the processor ID inputs
  localparam int IRQ_LINES     = 3;    // Interrupt request inputs
  localparam int FLAG_PINS     = 4;    // General flag pins
  localparam int TIMER_W       = 32;   // Timer count width
  localparam int SYNC_STAGES   = 2;    // Flip-flops in each pin synchroniser
  localparam int DMA_CH_A      = 7;    // Channel served by the first DMA pair
  localparam int DMA_CH_B      = 8;    // Channel served by the second DMA pair
  localparam int CLK_MHZ       = 20;   // Core clock rate
  localparam int TIMER_EXPIRED_CYCLES = 4;    // Timer expired pulse length in cycles
  localparam int TIMER_EXPIRED_CNT_W  = 3;    // Width of the pulse length counter
  localparam logic [ID_W-1:0] ID_SINGLE = 3'h0;  // ID of a single-processor system
  localparam logic [ID_W-1:0] ID_NONE   = 3'h7;  // No own line and not single
  localparam logic [TIMER_W-1:0] TIMER_RESET = 32'h0;  // Timer count after reset

  // Ownership of the external bus as seen by this processor
  typedef enum logic [1:0] {
    ST_SLAVE,
    ST_MASTER,
    ST_RELEASE,
    ST_HOST
  } hbap_state_e;
endpackage

// >>> core/hbap_sync.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
module hbap_sync
  import hbap_pkg::*;
#(
  parameter int         WIDTH    = 1,
  parameter logic [0:0] RST_LVL  = 1'h1
) (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= {WIDTH{RST_LVL}};
      sync_reg <= {WIDTH{RST_LVL}};
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule

// >>> core/hbap_irq_det.sv
// One interrupt line detector, edge or level mode
`timescale 1ns/1ns
module hbap_irq_det
  import hbap_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic irq_level_n,
  input  wire logic edge_mode,
  input  wire logic irq_ack,
  output logic      irq_pending
);
  logic prev_reg;
  logic latch_reg;
  logic fall;

  assign fall = prev_reg & ~irq_level_n;

  // Previous level for falling edge detection
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prev_reg <= 1'h1;
    end else begin
      prev_reg <= irq_level_n;
    end
  end

  // Edge latch, a new edge wins over the acknowledge
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      latch_reg <= 1'h0;
    end else if (fall) begin
      latch_reg <= 1'h1;
    end else if (irq_ack) begin
      latch_reg <= 1'h0;
    end
  end

  // Level mode follows the pin, edge mode the latch
  assign irq_pending = edge_mode ? latch_reg : ~irq_level_n;
endmodule

// >>> core/hbap_top.sv
// Bus ownership, host access and small pin functions of the processor
// Operation
// - Bus suspend low floats address, data, select and strobe outputs.
// - External access during suspend stalls until suspend is released.
// - Each interrupt input selectable as edge-triggered or level-sensitive.
// - Flag pins individually input or output; inputs testable, outputs driven.
// - Timer reaching zero while enabled pulses timer expired four cycles.
// - On host request the master floats its bus, then asserts grant.
// - Host request outranks every multiprocessor bus request.
// - Host grant stays low until the host releases its request.
// - Only the bus master drives host grant; others monitor it.
// - Host ready driven low to insert wait states on host accesses.
// - Host ready open drain by default, push-pull when configured.
// - Host ready driven only while chip select and host request asserted.
// - First DMA pin pair serves channel seven, second serves eight.
// - Drive only own request line, monitor all others for mastership.
// - ID value picks own request line; zero means single processor.
// - Arbitration select high gives rotating priority, low gives fixed.
`timescale 1ns/1ns
module hbap_top
  import hbap_pkg::*;
#(
  parameter int N_MP   = MP_LINES,
  parameter int N_IRQ  = IRQ_LINES,
  parameter int N_FLAG = FLAG_PINS,
  parameter int TW     = TIMER_W
) (
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire logic              bus_suspend_n,
  input  wire logic              host_req_n,
  input  wire logic              host_cs_n,
  input  wire logic              host_grant_n_in,
  output logic                   host_grant_n_out,
  output logic                   host_grant_n_oe,
  output logic                   host_grant_seen,
  input  wire logic [N_MP-1:0]   mp_bus_request_n_in,
  output logic      [N_MP-1:0]   mp_bus_request_n_out,
  output logic      [N_MP-1:0]   mp_bus_request_n_oe,
  input  wire logic [ID_W-1:0]   proc_id,
  input  wire logic              rotating_priority_sel,
  input  wire logic              core_ext_req,
  input  wire logic              core_ext_busy,
  output logic                   core_ext_go,
  output logic                   core_ext_stall,
  output logic                   bus_oe,
  output logic                   bus_master,
  output logic      [ID_W-1:0]   master_id,
  input  wire logic              host_access_wait,
  input  wire logic              ready_active_drive,
  output logic                   host_ready_out,
  output logic                   host_ready_oe,
  input  wire logic [N_IRQ-1:0]  irq_n,
  input  wire logic [N_IRQ-1:0]  irq_edge_mode,
  input  wire logic [N_IRQ-1:0]  irq_ack,
  output logic      [N_IRQ-1:0]  irq_pending,
  input  wire logic [N_FLAG-1:0] flag_in,
  input  wire logic [N_FLAG-1:0] flag_dir_out,
  input  wire logic [N_FLAG-1:0] flag_out_value,
  output logic      [N_FLAG-1:0] flag_out,
  output logic      [N_FLAG-1:0] flag_oe,
  output logic      [N_FLAG-1:0] flag_cond,
  input  wire logic              timer_enable,
  input  wire logic              timer_load,
  input  wire logic [TW-1:0]     timer_period,
  output logic      [TW-1:0]     timer_count,
  output logic                   timer_expired,
  input  wire logic              ext_dma_req_a_n,
  input  wire logic              ext_dma_req_b_n,
  input  wire logic              dma_ch_a_grant,
  input  wire logic              dma_ch_b_grant,
  output logic                   dma_ch_a_request,
  output logic                   dma_ch_b_request,
  output logic                   ext_dma_gnt_a_n,
  output logic                   ext_dma_gnt_b_n,
  output logic                   ext_dma_gnt_oe
);
  localparam int SYNC_W = 7 + N_MP + ID_W + N_IRQ + N_FLAG;

  logic [SYNC_W-1:0]  sync_raw;
  logic               suspend_s, host_req_s_n, host_cs_s_n, grant_s_n;
  logic               rot_s, dma_a_s_n, dma_b_s_n;
  logic [N_MP-1:0]    br_s_n;
  logic [ID_W-1:0]    id_s;
  logic [N_IRQ-1:0]   irq_s_n;
  logic [N_FLAG-1:0]  flag_s;
  logic [ID_W-1:0]    id_reg;
  logic [1:0]         id_cnt_reg;
  logic               single;
  logic               own_valid;
  logic               own_req;
  logic [N_MP-1:0]    req_vec;
  logic [ID_W-1:0]    master_reg, master_next;
  logic [ID_W-1:0]    last_reg;
  logic [ID_W-1:0]    winner;
  logic               have_bus;
  logic               host_wants;
  hbap_state_e        state_reg, state_next;
  logic               bus_oe_reg;
  logic               ready_reg, ready_oe_reg;
  logic [TW-1:0]      count_reg;
  logic [TIMER_EXPIRED_CNT_W-1:0] pulse_reg;
  logic               gnt_a_reg, gnt_b_reg;

  // Every asynchronous pin passes two flip-flops first
  hbap_sync #(.WIDTH(SYNC_W), .RST_LVL(1'h1)) u_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .pin_in   ({bus_suspend_n, host_req_n, host_cs_n, host_grant_n_in,
                rotating_priority_sel, ext_dma_req_a_n, ext_dma_req_b_n,
                mp_bus_request_n_in, proc_id, irq_n, flag_in}),
    .sync_out (sync_raw)
  );
  assign {suspend_s, host_req_s_n, host_cs_s_n, grant_s_n, rot_s, dma_a_s_n,
          dma_b_s_n, br_s_n, id_s, irq_s_n, flag_s} = sync_raw;

  // Processor ID followed until the synchroniser holds the pin value
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      id_reg     <= ID_NONE;
      id_cnt_reg <= 2'h0;
    end else if (id_cnt_reg != 2'(SYNC_STAGES + 1)) begin
      id_reg     <= id_s;
      id_cnt_reg <= id_cnt_reg + 2'h1;
    end
  end

  // ID decode: zero single, one to N_MP own line
  assign single    = (id_reg == ID_SINGLE);
  assign own_valid = !single && (int'(id_reg) <= N_MP);

  // Fixed or rotating winner among asserted request lines
  function automatic logic [ID_W-1:0] pick(input logic [N_MP-1:0] req,
                                           input logic rot,
                                           input logic [ID_W-1:0] last);
    int idx;
    logic [ID_W-1:0] res;
    res = ID_SINGLE;
    for (int i = N_MP - 1; i >= 0; i--) begin
      idx = rot ? ((int'(last) + i) % N_MP) : i;
      if (req[idx]) begin
        res = ID_W'(idx + 1);
      end
    end
    return res;
  endfunction

  // Own line taken from internal request, others from the pins
  always_comb begin
    req_vec = ~br_s_n;
    for (int i = 0; i < N_MP; i++) begin
      if (own_valid && (int'(id_reg) == i + 1)) begin
        req_vec[i] = own_req;
      end
    end
  end

  assign own_req    = core_ext_req | core_ext_busy | (master_reg == id_reg);
  assign winner     = pick(req_vec, rot_s, last_reg);
  assign host_wants = ~host_req_s_n;

  // Mastership frozen while the host holds or asks for the bus
  always_comb begin
    master_next = master_reg;
    if (host_wants || state_reg == ST_RELEASE || state_reg == ST_HOST) begin
      master_next = master_reg;
    end else if (master_reg == ID_SINGLE || !req_vec[master_reg - 3'h1]) begin
      master_next = winner;
    end
  end

  // Current and last master for rotating priority
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      master_reg <= ID_SINGLE;
      last_reg   <= ID_SINGLE;
    end else begin
      master_reg <= master_next;
      if (master_next != ID_SINGLE && master_next != master_reg) begin
        last_reg <= master_next;
      end
    end
  end

  assign have_bus = single || (own_valid && master_reg == id_reg);

  // Ownership sequence of this processor
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_SLAVE: begin
        if (have_bus) begin
          state_next = ST_MASTER;
        end
      end
      ST_MASTER: begin
        if (!have_bus) begin
          state_next = ST_SLAVE;
        end else if (host_wants && !core_ext_busy) begin
          state_next = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        state_next = host_wants ? ST_HOST : ST_MASTER;
      end
      ST_HOST: begin
        if (!host_wants) begin
          state_next = ST_MASTER;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_SLAVE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Bus drive enable, off while suspended or released to host
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bus_oe_reg <= 1'h0;
    end else begin
      bus_oe_reg <= (state_next == ST_MASTER) && suspend_s;
    end
  end

  assign bus_oe      = bus_oe_reg;
  assign bus_master  = have_bus;
  assign master_id   = master_reg;
  // Core access proceeds only in the master state while not suspended
  assign core_ext_go    = core_ext_req && state_reg == ST_MASTER && suspend_s;
  assign core_ext_stall = core_ext_req && !core_ext_go;

  // Host grant driven by the master only, low through the host phase
  assign host_grant_n_out = (state_reg != ST_HOST);
  assign host_grant_n_oe  = (state_reg != ST_SLAVE);
  assign host_grant_seen  = ~grant_s_n;

  // Own request line only, open elsewhere
  always_comb begin
    mp_bus_request_n_out = {N_MP{1'h1}};
    mp_bus_request_n_oe  = {N_MP{1'h0}};
    for (int i = 0; i < N_MP; i++) begin
      if (own_valid && (int'(id_reg) == i + 1)) begin
        mp_bus_request_n_out[i] = ~own_req;
        mp_bus_request_n_oe[i]  = 1'h1;
      end
    end
  end

  // Host ready, wait low during internal access, drive only when selected
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ready_reg    <= 1'h1;
      ready_oe_reg <= 1'h0;
    end else begin
      ready_reg    <= ~host_access_wait;
      ready_oe_reg <= !host_cs_s_n && !host_req_s_n &&
                      (ready_active_drive || host_access_wait);
    end
  end

  assign host_ready_out = ready_reg;
  assign host_ready_oe  = ready_oe_reg;

  // Interrupt detectors, one per line
  for (genvar g = 0; g < N_IRQ; g++) begin : g_irq
    hbap_irq_det u_det (
      .core_clk    (core_clk),
      .nrst        (nrst),
      .irq_level_n (irq_s_n[g]),
      .edge_mode   (irq_edge_mode[g]),
      .irq_ack     (irq_ack[g]),
      .irq_pending (irq_pending[g])
    );
  end

  // Flag pins, direction per bit
  assign flag_out  = flag_out_value;
  assign flag_oe   = flag_dir_out;
  assign flag_cond = flag_s & ~flag_dir_out;

  // Timer count, reloads the period after reaching zero
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      count_reg <= TIMER_RESET;
    end else if (timer_load) begin
      count_reg <= timer_period;
    end else if (timer_enable) begin
      count_reg <= (count_reg == TIMER_RESET) ? timer_period : count_reg - TW'(1);
    end
  end

  // Expired pulse, four cycles from the decrement to zero
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pulse_reg <= 3'h0;
    end else if (timer_enable && !timer_load && count_reg == TW'(1)) begin
      pulse_reg <= TIMER_EXPIRED_CNT_W'(TIMER_EXPIRED_CYCLES);
    end else if (pulse_reg != 3'h0) begin
      pulse_reg <= pulse_reg - 3'h1;
    end
  end

  assign timer_count   = count_reg;
  assign timer_expired = (pulse_reg != 3'h0);

  // External DMA pairs: first to channel A, second to channel B
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gnt_a_reg <= 1'h1;
      gnt_b_reg <= 1'h1;
    end else begin
      gnt_a_reg <= ~dma_ch_a_grant;
      gnt_b_reg <= ~dma_ch_b_grant;
    end
  end

  assign dma_ch_a_request = ~dma_a_s_n;
  assign dma_ch_b_request = ~dma_b_s_n;
  assign ext_dma_gnt_a_n  = gnt_a_reg;
  assign ext_dma_gnt_b_n  = gnt_b_reg;
  assign ext_dma_gnt_oe   = bus_oe_reg;
endmodule

// >>> verification/hbap_properties.sv
// Port-level checks for the bus arbitration pin block
`timescale 1ns/1ns
module hbap_properties
  import hbap_pkg::*;
#(
  parameter int N_MP   = MP_LINES,
  parameter int N_FLAG = FLAG_PINS
) (
  input wire logic              core_clk,
  input wire logic              nrst,
  input wire logic              bus_suspend_n,
  input wire logic              host_req_n,
  input wire logic              host_cs_n,
  input wire logic              host_grant_n_out,
  input wire logic              host_grant_n_oe,
  input wire logic              bus_oe,
  input wire logic              core_ext_req,
  input wire logic              core_ext_busy,
  input wire logic              core_ext_go,
  input wire logic              core_ext_stall,
  input wire logic [N_MP-1:0]   mp_bus_request_n_oe,
  input wire logic [ID_W-1:0]   proc_id,
  input wire logic [ID_W-1:0]   master_id,
  input wire logic              host_access_wait,
  input wire logic              ready_active_drive,
  input wire logic              host_ready_out,
  input wire logic              host_ready_oe,
  input wire logic              timer_expired,
  input wire logic              ext_dma_req_a_n,
  input wire logic              ext_dma_req_b_n,
  input wire logic              dma_ch_a_grant,
  input wire logic              dma_ch_b_grant,
  input wire logic              dma_ch_a_request,
  input wire logic              dma_ch_b_request,
  input wire logic              ext_dma_gnt_a_n,
  input wire logic              ext_dma_gnt_b_n,
  input wire logic [N_FLAG-1:0] flag_dir_out,
  input wire logic [N_FLAG-1:0] flag_out_value,
  input wire logic [N_FLAG-1:0] flag_out,
  input wire logic [N_FLAG-1:0] flag_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // Bus drive and stall under suspend
  a_suspend_float: assert property (!bus_suspend_n [*4] |-> !bus_oe)
    else $error("bus driven while suspended");
  a_suspend_stall: assert property ((!bus_suspend_n [*3]) ##0 core_ext_req |-> core_ext_stall && !core_ext_go)
    else $error("access not stalled while suspended");
  // Host grant sequencing
  a_grant_float: assert property ($fell(host_grant_n_out) |-> !bus_oe && !$past(bus_oe))
    else $error("grant given while bus driven");
  a_grant_after_busy: assert property ($fell(host_grant_n_out) |-> !$past(core_ext_busy, 2))
    else $error("grant given during access");
  a_grant_hold: assert property (!host_grant_n_out && !host_req_n |=> !host_grant_n_out)
    else $error("grant dropped while host requests");
  a_grant_return: assert property (host_req_n [*4] |-> host_grant_n_out)
    else $error("grant kept after host release");
  a_grant_driven: assert property (!host_grant_n_out |-> host_grant_n_oe)
    else $error("grant low but not driven");
  a_host_freeze: assert property (!host_req_n [*3] |=> $stable(master_id))
    else $error("mastership moved during host request");
  // Host ready pin
  a_ready_gate: assert property (host_ready_oe |-> !$past(host_cs_n, 3) && !$past(host_req_n, 3))
    else $error("ready driven without select and request");
  a_ready_level: assert property (host_ready_oe |-> host_ready_out == !$past(host_access_wait))
    else $error("ready level wrong");
  a_ready_drain: assert property (host_ready_oe && host_ready_out |-> $past(ready_active_drive))
    else $error("ready driven high in open drain mode");
  // Request lines, timer, DMA pairs and flags
  a_own_line: assert property (mp_bus_request_n_oe != 0 |-> mp_bus_request_n_oe == (1 << (proc_id - 1)))
    else $error("wrong request line driven");
  a_timer_pulse: assert property ($rose(timer_expired) |-> timer_expired [*4] ##1 !timer_expired)
    else $error("timer expired pulse length wrong");
  a_dma_map: assert property (dma_ch_a_request == !$past(ext_dma_req_a_n, 2) && dma_ch_b_request == !$past(ext_dma_req_b_n, 2) && ext_dma_gnt_a_n == !$past(dma_ch_a_grant) && ext_dma_gnt_b_n == !$past(dma_ch_b_grant))
    else $error("dma pair mapping wrong");
  a_flag_drive: assert property (flag_oe == flag_dir_out && flag_out == flag_out_value)
    else $error("flag output wrong");
endmodule

bind hbap_top hbap_properties #(.N_MP(N_MP), .N_FLAG(N_FLAG)) hbap_properties_i (.*);

// >>> verification/hbap_far_side.sv
// Host processor and peer processors seen from the shared bus pins
`timescale 1ns/1ns
module hbap_far_side
  import hbap_pkg::*;
(
  input  wire logic                want_bus,
  input  wire logic                want_access,
  input  wire logic [MP_LINES-1:0] peer_req,
  input  wire logic                grant_out,
  input  wire logic                grant_oe,
  input  wire logic [MP_LINES-1:0] req_out,
  input  wire logic [MP_LINES-1:0] req_oe,
  output logic                     host_req_n,
  output logic                     host_cs_n,
  output logic                     grant_wire,
  output logic [MP_LINES-1:0]      req_wire
);
  // Host keeps its request and select low for as long as it wants them
  assign host_req_n = !want_bus;
  assign host_cs_n  = !want_access;
  // Grant line held high by the peer master when this end does not drive it
  assign grant_wire = grant_oe ? grant_out : 1'h1;
  // Own line never pulled, others pulled high unless a peer requests
  assign req_wire = (req_oe & req_out) | (~req_oe & ~peer_req);
endmodule

// >>> verification/hbap_tb_top.sv
// Self-checking bench for the bus arbitration pin block
`timescale 1ns/1ns
module hbap_tb_top
  import hbap_pkg::*;
;
  logic core_clk, nrst, bus_suspend_n, host_req_n, host_cs_n, host_grant_n_in;
  logic host_grant_n_out, host_grant_n_oe, host_grant_seen, want_bus, want_access;
  logic [MP_LINES-1:0] mp_bus_request_n_in, mp_bus_request_n_out, mp_bus_request_n_oe, peer_req;
  logic [ID_W-1:0] proc_id, master_id;
  logic rotating_priority_sel, core_ext_req, core_ext_busy, core_ext_go, core_ext_stall;
  logic bus_oe, bus_master, host_access_wait, ready_active_drive, host_ready_out, host_ready_oe;
  logic [IRQ_LINES-1:0] irq_n, irq_edge_mode, irq_ack, irq_pending;
  logic [FLAG_PINS-1:0] flag_in, flag_dir_out, flag_out_value, flag_out, flag_oe, flag_cond;
  logic timer_enable, timer_load, timer_expired;
  logic [TIMER_W-1:0] timer_period, timer_count;
  logic ext_dma_req_a_n, ext_dma_req_b_n, dma_ch_a_grant, dma_ch_b_grant, dma_ch_a_request;
  logic dma_ch_b_request, ext_dma_gnt_a_n, ext_dma_gnt_b_n, ext_dma_gnt_oe;
  int   bad_count, samples_checked, n;
  typedef struct { logic [3:0] dir, val, fin, cond; logic ga, ra_n; } hbap_row_s;
  hbap_row_s rows [3] = '{'{4'hF, 4'hA, 4'h5, 4'h0, 1'h1, 1'h0},
                          '{4'h0, 4'h0, 4'hC, 4'hC, 1'h0, 1'h1},
                          '{4'h3, 4'h1, 4'hF, 4'hC, 1'h1, 1'h1}};

  hbap_top hbap_top_i (.*);
  hbap_far_side hbap_far_side_i (
    .want_bus    (want_bus),
    .want_access (want_access),
    .peer_req    (peer_req),
    .grant_out   (host_grant_n_out),
    .grant_oe    (host_grant_n_oe),
    .req_out     (mp_bus_request_n_out),
    .req_oe      (mp_bus_request_n_oe),
    .host_req_n  (host_req_n),
    .host_cs_n   (host_cs_n),
    .grant_wire  (host_grant_n_in),
    .req_wire    (mp_bus_request_n_in)
  );

  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (exp !== got) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(int k);
    repeat (k) @(negedge core_clk);
  endtask
  task automatic finish_test();
    if (bad_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Reset with the ID held still across it
  task automatic do_reset(logic [2:0] id);
    nrst = 1'h0;
    proc_id = id;
    {ext_dma_req_a_n, ext_dma_req_b_n, dma_ch_a_grant, dma_ch_b_grant} = 4'hC;
    cyc(4);
    chk("reset_pins", 6'h11, {bus_oe, host_grant_n_out, host_grant_n_oe, host_ready_oe,
                              timer_expired, ext_dma_gnt_a_n});
    nrst = 1'h1;
    cyc(4);
  endtask

  // Clock at 20 MHz
  initial begin
    core_clk = 1'h0;
    forever #25 core_clk = ~core_clk;
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    finish_test();
  end
  // Main sequence
  initial begin
    {bus_suspend_n, irq_n, ext_dma_req_a_n, ext_dma_req_b_n} = '1;
    {want_bus, want_access, peer_req, rotating_priority_sel, core_ext_req, core_ext_busy} = '0;
    {host_access_wait, ready_active_drive, irq_edge_mode, irq_ack, flag_in, flag_dir_out} = '0;
    {flag_out_value, timer_enable, timer_load, timer_period, dma_ch_a_grant, dma_ch_b_grant} = '0;
    bad_count = 0;
    samples_checked = 0;
    do_reset(3'h0);
    foreach (rows[i]) begin
      flag_dir_out = rows[i].dir;
      flag_out_value = rows[i].val;
      flag_in = rows[i].fin;
      dma_ch_a_grant = rows[i].ga;
      dma_ch_b_grant = !rows[i].ga;
      ext_dma_req_a_n = rows[i].ra_n;
      ext_dma_req_b_n = !rows[i].ra_n;
      cyc(3);
      chk("flag_pins", {rows[i].val, rows[i].dir}, {flag_out, flag_oe});
      chk("flag_cond", rows[i].cond, flag_cond);
      chk("dma_gnt", {!rows[i].ga, rows[i].ga}, {ext_dma_gnt_a_n, ext_dma_gnt_b_n});
      chk("dma_req", {!rows[i].ra_n, rows[i].ra_n}, {dma_ch_a_request, dma_ch_b_request});
    end
    // Single processor owns the bus; suspend used as deadlock recovery
    chk("single", {3'h7, 6'h0},
        {bus_master, bus_oe, ext_dma_gnt_oe, mp_bus_request_n_oe});
    core_ext_req = 1'h1;
    bus_suspend_n = 1'h0;
    cyc(3);
    chk("suspended", 3'h1, {bus_oe, core_ext_go, core_ext_stall});
    bus_suspend_n = 1'h1;
    cyc(3);
    chk("resumed", 3'h6, {bus_oe, core_ext_go, core_ext_stall});
    core_ext_req = 1'h0;
    // Host request during an access in flight
    core_ext_busy = 1'h1;
    want_bus = 1'h1;
    cyc(6);
    chk("grant_wait", 2'h3, {host_grant_n_out, bus_oe});
    core_ext_busy = 1'h0;
    cyc(4);
    chk("granted", 4'h3, {host_grant_n_out, bus_oe, host_grant_n_oe, host_grant_seen});
    want_access = 1'h1;
    host_access_wait = 1'h1;
    cyc(4);
    chk("ready_wait", 2'h2, {host_ready_oe, host_ready_out});
    host_access_wait = 1'h0;
    cyc(2);
    chk("ready_drain", 1'h0, host_ready_oe);
    ready_active_drive = 1'h1;
    cyc(2);
    chk("ready_drive", 2'h3, {host_ready_oe, host_ready_out});
    want_access = 1'h0;
    cyc(4);
    chk("ready_no_cs", 1'h0, host_ready_oe);
    ready_active_drive = 1'h0;
    cyc(10);
    chk("grant_held", 1'h0, host_grant_n_out);
    want_bus = 1'h0;
    cyc(4);
    chk("host_done", 3'h7, {host_grant_n_out, host_grant_n_oe, bus_oe});
    // Interrupt lines in both modes
    for (int i = 0; i < IRQ_LINES; i++) begin
      irq_n[i] = 1'h0;
      cyc(3);
      chk("irq_level_on", 1'h1, irq_pending[i]);
      irq_n[i] = 1'h1;
      irq_ack[i] = 1'h1;
      cyc(3);
      chk("irq_level_off", 1'h0, irq_pending[i]);
      irq_ack[i] = 1'h0;
      irq_edge_mode[i] = 1'h1;
      cyc(1);
      chk("irq_edge_idle", 1'h0, irq_pending[i]);
      irq_n[i] = 1'h0;
      cyc(1);
      irq_n[i] = 1'h1;
      cyc(4);
      chk("irq_edge_held", 1'h1, irq_pending[i]);
      irq_ack[i] = 1'h1;
      cyc(1);
      irq_ack[i] = 1'h0;
      cyc(1);
      chk("irq_edge_clr", 1'h0, irq_pending[i]);
    end
    // Timer expiry pulse length
    timer_period = 32'h5;
    timer_load = 1'h1;
    cyc(1);
    timer_load = 1'h0;
    chk("timer_load", 32'h5, timer_count);
    timer_enable = 1'h1;
    n = 0;
    while (timer_expired !== 1'h1 && n < 20) begin
      cyc(1);
      n++;
    end
    if (n == 20) begin
      bad_count++;
      finish_test();
    end
    n = 0;
    while (timer_expired === 1'h1 && n < 10) begin
      cyc(1);
      n++;
    end
    chk("timer_pulse", 4, n);
    timer_enable = 1'h0;
    // Multiprocessor arbitration, fixed then rotating
    do_reset(3'h3);
    chk("own_line_oe", 6'h04, mp_bus_request_n_oe);
    peer_req = 6'h11;
    cyc(4);
    chk("fixed_pick", 3'h1, master_id);
    peer_req = 6'h12;
    cyc(4);
    chk("fixed_next", 3'h2, master_id);
    rotating_priority_sel = 1'h1;
    cyc(3);
    peer_req = 6'h11;
    cyc(4);
    chk("rotate_pick", 3'h5, master_id);
    core_ext_req = 1'h1;
    cyc(2);
    chk("own_req", 1'h0, mp_bus_request_n_out[2]);
    core_ext_req = 1'h0;
    finish_test();
  end
endmodule
